// ### ctop_pkg.sv
// constants, types and register map of the channel-two output processing block
// How it works
// - channel two shows one of five quantities; an indicator shows which
// - noise in dBm assumes a 50 ohm load
// - ratio mode multiplies in-phase and quadrature by 1.0 V over the aux input
// - phase comes from quadrature over in-phase; negative ratio input shifts it 180 deg
// - there is no phase offset; only the reference phase moves phase
// - with 18 or 24 dB/oct filtering the in-phase output updates four times slower
// - numeric display refreshes at a fixed 2 Hz
// - bar-graph refreshes at 64 Hz
// - readout and storage values update at most at 512 Hz
// - noise recomputed at 512 Hz up to 30 ms, else 25.6 times per time constant
// - offsets are added before ratio and filtering; phase uses corrected values
// - a reference phase change rotates the offset vector by minus that change
// - both offset enables always switch together
// - auto on either quantity offsets both and enables both
// - channel-two on/off works only while quadrature is shown; last value reapplied
// - offset indicator lit when the shown quantity is touched by the offsets
// - auto loads minus the last raw quadrature sample, taken before offset and ratio, and enables the offset
// - modify shows quadrature offset on the reference display until another view key
// - offsets are held as a fraction of full-scale sensitivity
// - a steady 1.000 V ratio input equals ratio off; either sign accepted
// - two ratio modes, by aux input one or two; phase is computed from the ratioed values; the shown aux input two is never ratioed
// - ratio after offsets, before filters; noise comes from the ratioed quadrature
// - overflow indicator when the ratio aux input exceeds plus or minus 10.5 V
// - underflow indicator when the ratio aux input magnitude is below 50 mV
package ctop_pkg;
	localparam int unsigned CLK_HZ = 125_000_000;
	localparam int unsigned DISP_HZ = 2;
	localparam int unsigned BAR_HZ = 64;
	localparam int unsigned READ_HZ = 512;
	// least periods, rounded up to whole cycles
	localparam int unsigned DISP_CYC = (CLK_HZ + DISP_HZ - 1) / DISP_HZ;
	localparam int unsigned BAR_CYC = (CLK_HZ + BAR_HZ - 1) / BAR_HZ;
	localparam int unsigned READ_CYC = (CLK_HZ + READ_HZ - 1) / READ_HZ;
	localparam int unsigned NOISE_FAST_TC_MS = 30;
	localparam int unsigned NOISE_FAST_TC_US = NOISE_FAST_TC_MS * 1000;
	// 25.6 updates per time constant: cycles = tc_us * (CLK_HZ / 1e6) * 10 / 256
	localparam int unsigned NOISE_MUL = CLK_HZ / 100_000;
	localparam int unsigned NOISE_DIV_SHIFT = 8;
	localparam int unsigned AUX_ONE_VOLT_MV = 1000;
	localparam int unsigned AUX_OVER_MV = 10500;
	localparam int unsigned AUX_UNDER_MV = 50;
	localparam int unsigned LOAD_OHM = 50;
	// 10*log10(1 V^2 / LOAD_OHM / 1 mW) in 0.01 dB
	localparam int signed LOAD_DBM_CENTI = 1301;
	// 20*log10(1 uV) in 0.01 dB, one sample count is 1 uV
	localparam int signed LSB_DB_CENTI = -12000;
	localparam int signed DB_PER_OCT_CENTI = 602;
	localparam int signed DBM_FLOOR_CENTI = -22000;
	localparam int signed DEG_CENTI_CIRCLE = 36000;
	localparam int unsigned SW = 16;
	localparam int unsigned CW = 20;
	localparam int unsigned RW = 18;
	localparam int unsigned DIV_N = 28;
	localparam int unsigned CORDIC_N = 16;
	localparam int unsigned PCT_SHIFT = 15;
	localparam logic [14:0] CORDIC_GAIN_INV = 15'h4DBA;
	localparam logic [15:0] HALF_TURN = 16'h8000;
	localparam logic signed [15:0] KNOB_STEP = 16'sh0040;
	localparam logic [15:0] ATAN_TAB [CORDIC_N] = '{16'h2000, 16'h12E4, 16'h09FB, 16'h0511,
		16'h028B, 16'h0146, 16'h00A3, 16'h0051, 16'h0029, 16'h0014, 16'h000A, 16'h0005,
		16'h0003, 16'h0001, 16'h0001, 16'h0000};
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_XOFS = 8'h04;
	localparam logic [7:0] REG_YOFS = 8'h08;
	localparam logic [7:0] REG_STAT = 8'h0C;
	localparam logic [7:0] REG_READ = 8'h10;
	localparam int unsigned CTRL_SEL_LSB = 0;
	localparam int unsigned CTRL_EN_BIT = 3;
	localparam int unsigned STAT_OVER_BIT = 4;
	localparam int unsigned STAT_UNDER_BIT = 5;
	localparam int unsigned STAT_BUSY_BIT = 6;
	localparam logic signed [15:0] OFS_RST = 16'sh0000;
	typedef enum logic [2:0] {SEL_Y, SEL_PHASE, SEL_NOISE_V, SEL_NOISE_DBM, SEL_AUX2} ctop_sel_t;
	localparam int unsigned SEL_COUNT = 5;
	typedef enum logic [1:0] {RATIO_OFF, RATIO_AUX1, RATIO_AUX2} ctop_ratio_t;
	typedef enum logic [1:0] {SLOPE_6, SLOPE_12, SLOPE_18, SLOPE_24} ctop_slope_t;
	typedef struct packed {
		logic signed [SW-1:0] x;
		logic signed [SW-1:0] y;
	} ctop_xy_t;
endpackage

// ### ctop_core.sv
// channel-two output processing: offsets, ratio, phase, noise and update pacing
`timescale 1ns/1ps
module ctop_core #(
	parameter int unsigned DISP_CYC = ctop_pkg::DISP_CYC,
	parameter int unsigned BAR_CYC = ctop_pkg::BAR_CYC,
	parameter int unsigned READ_CYC = ctop_pkg::READ_CYC
) (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic sample_valid_i,
	output logic sample_ready_o,
	input wire ctop_pkg::ctop_xy_t sample_i,
	input wire logic signed [15:0] aux1_i,
	input wire logic signed [15:0] aux2_i,
	input wire logic [3:0] sens_shift_i,
	input wire logic [15:0] ref_phase_i,
	input wire ctop_pkg::ctop_slope_t slope_i,
	input wire logic [31:0] tc_us_i,
	input wire ctop_pkg::ctop_ratio_t ratio_mode_i,
	input wire logic key_display_i,
	input wire logic key_onoff_i,
	input wire logic key_auto_i,
	input wire logic key_modify_i,
	input wire logic key_ref_view_i,
	input wire logic knob_step_i,
	input wire logic knob_up_i,
	input wire logic ch1_onoff_i,
	input wire logic ch1_auto_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	output logic [4:0] disp_ind_o,
	output logic signed [31:0] disp_value_o,
	output logic signed [31:0] bar_value_o,
	output logic signed [31:0] readout_value_o,
	output logic readout_stb_o,
	output logic signed [17:0] x_out_o,
	output logic x_out_stb_o,
	output logic signed [17:0] y_out_o,
	output logic y_out_stb_o,
	output logic offs_ind_o,
	output logic [1:0] ratio_ind_o,
	output logic overflow_o,
	output logic underflow_o,
	output logic ref_show_offs_o,
	output logic signed [15:0] ref_offs_pct_o
);
	localparam int unsigned SW = ctop_pkg::SW;
	localparam int unsigned CW = ctop_pkg::CW;
	localparam int unsigned RW = ctop_pkg::RW;
	localparam int unsigned DN = ctop_pkg::DIV_N;
	localparam int unsigned PER [3] = '{DISP_CYC, BAR_CYC, READ_CYC};

	initial begin
		if (DISP_CYC == 0 || BAR_CYC == 0 || READ_CYC == 0) begin
			$error("ctop_core: tick periods must be at least one cycle");
		end
	end

	typedef enum logic [2:0] {ST_IDLE, ST_DIV, ST_FIX, ST_LOAD, ST_VEC, ST_ROT, ST_DONE}
		ctop_st_t;

	function automatic logic signed [15:0] sat16(input logic signed [39:0] v);
		if (v > 40'sd32767) begin
			return 16'sh7FFF;
		end else if (v < -40'sd32768) begin
			return 16'sh8000;
		end
		return v[15:0];
	endfunction

	// noise magnitude to 0.01 dBm using a piecewise-linear log2
	function automatic logic signed [31:0] to_dbm(input logic [CW-1:0] v);
		logic [4:0] msb;
		logic [CW-1:0] norm;
		logic [31:0] frac;
		msb = 5'h00;
		for (int i = 0; i < CW; i++) begin
			if (v[i]) begin
				msb = 5'(i);
			end
		end
		norm = v << (5'(CW - 1) - msb);
		frac = {24'h000000, norm[CW-2 -: 8]};
		if (v == '0) begin
			return ctop_pkg::DBM_FLOOR_CENTI;
		end
		return $signed({27'h0000000, msb}) * ctop_pkg::DB_PER_OCT_CENTI
			+ $signed(32'(frac * 32'(ctop_pkg::DB_PER_OCT_CENTI)) >> 8)
			+ ctop_pkg::LSB_DB_CENTI + ctop_pkg::LOAD_DBM_CENTI;
	endfunction

	ctop_pkg::ctop_sel_t sel_r;
	ctop_st_t st_r;
	logic ofs_en_r;
	logic signed [15:0] xofs_r;
	logic signed [15:0] yofs_r;
	logic view_offs_r;
	logic [15:0] ref_prev_r;
	logic [15:0] ang_acc_r;
	logic rot_pend_r;
	logic is_rot_r;
	logic [4:0] cnt_r;
	logic signed [CW-1:0] cx_r;
	logic signed [CW-1:0] cy_r;
	logic [15:0] cz_r;
	logic [DN-1:0] dq_r [2];
	logic [DN:0] drem_r [2];
	logic [DN-1:0] dq_nxt [2];
	logic [DN:0] drem_nxt [2];
	logic [1:0] neg_r;
	logic [15:0] den_r;
	ctop_pkg::ctop_xy_t raw_r;
	logic signed [RW-1:0] rx_r;
	logic signed [RW-1:0] ry_r;
	logic signed [31:0] phase_cd_r;
	logic done_r;
	logic rot_done_r;
	logic signed [15:0] aux_sel;
	logic [15:0] aux_mag;
	logic signed [RW-1:0] xo_abs;
	logic signed [RW-1:0] yo_abs;
	logic signed [RW-1:0] corr_x;
	logic signed [RW-1:0] corr_y;
	logic ratio_on;
	logic auto_go;
	logic onoff_go;
	logic [2:0] tick;
	logic noise_tick;
	logic [39:0] noise_cnt_r;
	logic [39:0] noise_per;
	logic signed [CW-1:0] navg_r;
	logic signed [CW-1:0] ndev_r;
	logic signed [CW-1:0] ndiff;
	logic signed [CW-1:0] nabs;
	logic signed [CW-1:0] noise_v_r;
	logic signed [31:0] noise_dbm_r;
	logic signed [31:0] qty;
	logic [1:0] xq_cnt_r;
	logic signed [39:0] gx;
	logic signed [39:0] gy;

	assign ratio_on = ratio_mode_i != ctop_pkg::RATIO_OFF;
	assign aux_sel = (ratio_mode_i == ctop_pkg::RATIO_AUX2) ? aux2_i : aux1_i;
	assign aux_mag = aux_sel[15] ? 16'(-aux_sel) : aux_sel;
	// offset fraction of full scale back to sample counts
	assign xo_abs = RW'(($signed({{24{xofs_r[15]}}, xofs_r}) <<< sens_shift_i)
		>>> ctop_pkg::PCT_SHIFT);
	assign yo_abs = RW'(($signed({{24{yofs_r[15]}}, yofs_r}) <<< sens_shift_i)
		>>> ctop_pkg::PCT_SHIFT);
	assign corr_x = RW'(sample_i.x) + (ofs_en_r ? xo_abs : RW'(0));
	assign corr_y = RW'(sample_i.y) + (ofs_en_r ? yo_abs : RW'(0));
	// no sample while busy, while a rotation waits, or while its result is written back
	assign sample_ready_o = st_r == ST_IDLE && !rot_pend_r && !rot_done_r;

	always_comb begin
		for (int k = 0; k < 2; k++) begin
			drem_nxt[k] = {drem_r[k][DN-1:0], dq_r[k][DN-1]};
			dq_nxt[k] = {dq_r[k][DN-2:0], 1'b0};
			if (drem_nxt[k] >= {13'h0000, den_r}) begin
				drem_nxt[k] = drem_nxt[k] - {13'h0000, den_r};
				dq_nxt[k][0] = 1'b1;
			end
		end
	end

	// shared engine: ratio divide, phase vectoring, offset rotation
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st_r <= ST_IDLE;
			is_rot_r <= 1'b0;
			cnt_r <= 5'h00;
			cx_r <= '0;
			cy_r <= '0;
			cz_r <= 16'h0000;
			dq_r <= '{default: '0};
			drem_r <= '{default: '0};
			neg_r <= 2'h0;
			den_r <= 16'h0000;
			raw_r <= '0;
			rx_r <= '0;
			ry_r <= '0;
			phase_cd_r <= 32'sh00000000;
			done_r <= 1'b0;
			rot_done_r <= 1'b0;
		end else begin
			done_r <= 1'b0;
			rot_done_r <= 1'b0;
			case (st_r)
				ST_IDLE: begin
					cnt_r <= 5'h00;
					if (rot_pend_r && !rot_done_r) begin
						is_rot_r <= 1'b1;
						// fold angles beyond a quarter turn into range
						if (ang_acc_r[15] ^ ang_acc_r[14]) begin
							cx_r <= -CW'(xofs_r);
							cy_r <= -CW'(yofs_r);
							cz_r <= ang_acc_r + ctop_pkg::HALF_TURN;
						end else begin
							cx_r <= CW'(xofs_r);
							cy_r <= CW'(yofs_r);
							cz_r <= ang_acc_r;
						end
						st_r <= ST_ROT;
					end else if (sample_valid_i && !rot_done_r) begin
						is_rot_r <= 1'b0;
						raw_r <= sample_i;
						if (ratio_on) begin
							// |v| * 1000 / |aux|, so 1000 mV gives v exactly
							dq_r[0] <= DN'(RW'(corr_x[RW-1] ? -corr_x : corr_x)
								* ctop_pkg::AUX_ONE_VOLT_MV);
							dq_r[1] <= DN'(RW'(corr_y[RW-1] ? -corr_y : corr_y)
								* ctop_pkg::AUX_ONE_VOLT_MV);
							drem_r <= '{default: '0};
							den_r <= aux_mag;
							neg_r <= {corr_y[RW-1] ^ aux_sel[15], corr_x[RW-1] ^ aux_sel[15]};
							st_r <= ST_DIV;
						end else begin
							rx_r <= corr_x;
							ry_r <= corr_y;
							st_r <= ST_LOAD;
						end
					end
				end
				ST_DIV: begin
					dq_r <= dq_nxt;
					drem_r <= drem_nxt;
					cnt_r <= cnt_r + 5'h01;
					if (cnt_r == 5'(DN - 1)) begin
						st_r <= ST_FIX;
					end
				end
				ST_FIX: begin
					// saturate and restore sign; negative aux flips both components
					rx_r <= (dq_r[0] > DN'(2 ** (RW - 1) - 1)) ? (neg_r[0] ? -RW'(2 ** (RW - 1) - 1)
						: RW'(2 ** (RW - 1) - 1)) : (neg_r[0] ? -RW'(dq_r[0]) : RW'(dq_r[0]));
					ry_r <= (dq_r[1] > DN'(2 ** (RW - 1) - 1)) ? (neg_r[1] ? -RW'(2 ** (RW - 1) - 1)
						: RW'(2 ** (RW - 1) - 1)) : (neg_r[1] ? -RW'(dq_r[1]) : RW'(dq_r[1]));
					st_r <= ST_LOAD;
				end
				ST_LOAD: begin
					cnt_r <= 5'h00;
					// left half plane starts at half a turn, giving 180 deg on sign flip
					cx_r <= rx_r[RW-1] ? -CW'(rx_r) : CW'(rx_r);
					cy_r <= rx_r[RW-1] ? -CW'(ry_r) : CW'(ry_r);
					cz_r <= rx_r[RW-1] ? ctop_pkg::HALF_TURN : 16'h0000;
					st_r <= ST_VEC;
				end
				ST_VEC: begin
					if (!cy_r[CW-1]) begin
						cx_r <= cx_r + (cy_r >>> cnt_r);
						cy_r <= cy_r - (cx_r >>> cnt_r);
						cz_r <= cz_r + ctop_pkg::ATAN_TAB[cnt_r[3:0]];
					end else begin
						cx_r <= cx_r - (cy_r >>> cnt_r);
						cy_r <= cy_r + (cx_r >>> cnt_r);
						cz_r <= cz_r - ctop_pkg::ATAN_TAB[cnt_r[3:0]];
					end
					cnt_r <= cnt_r + 5'h01;
					if (cnt_r == 5'(ctop_pkg::CORDIC_N - 1)) begin
						st_r <= ST_DONE;
					end
				end
				ST_ROT: begin
					if (!cz_r[15]) begin
						cx_r <= cx_r - (cy_r >>> cnt_r);
						cy_r <= cy_r + (cx_r >>> cnt_r);
						cz_r <= cz_r - ctop_pkg::ATAN_TAB[cnt_r[3:0]];
					end else begin
						cx_r <= cx_r + (cy_r >>> cnt_r);
						cy_r <= cy_r - (cx_r >>> cnt_r);
						cz_r <= cz_r + ctop_pkg::ATAN_TAB[cnt_r[3:0]];
					end
					cnt_r <= cnt_r + 5'h01;
					if (cnt_r == 5'(ctop_pkg::CORDIC_N - 1)) begin
						st_r <= ST_DONE;
					end
				end
				ST_DONE: begin
					if (is_rot_r) begin
						rot_done_r <= 1'b1;
					end else begin
						// phase from quadrature over in-phase of corrected values
						phase_cd_r <= ($signed({{16{cz_r[15]}}, cz_r})
							* ctop_pkg::DEG_CENTI_CIRCLE) >>> 16;
						done_r <= 1'b1;
					end
					st_r <= ST_IDLE;
				end
				default: st_r <= ST_IDLE;
			endcase
		end
	end

	// reference phase tracking; a new change in the start cycle is kept
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ref_prev_r <= 16'h0000;
			ang_acc_r <= 16'h0000;
			rot_pend_r <= 1'b0;
		end else begin
			ref_prev_r <= ref_phase_i;
			if (st_r == ST_IDLE && rot_pend_r && !rot_done_r) begin
				ang_acc_r <= ref_prev_r - ref_phase_i;
				rot_pend_r <= ref_phase_i != ref_prev_r;
			end else if (ref_phase_i != ref_prev_r) begin
				ang_acc_r <= ang_acc_r - (ref_phase_i - ref_prev_r);
				rot_pend_r <= 1'b1;
			end
		end
	end

	assign gx = ($signed({{20{cx_r[CW-1]}}, cx_r}) * $signed({25'h0, ctop_pkg::CORDIC_GAIN_INV}))
		>>> ctop_pkg::PCT_SHIFT;
	assign gy = ($signed({{20{cy_r[CW-1]}}, cy_r}) * $signed({25'h0, ctop_pkg::CORDIC_GAIN_INV}))
		>>> ctop_pkg::PCT_SHIFT;
	assign auto_go = (key_auto_i && sel_r == ctop_pkg::SEL_Y) || ch1_auto_i;
	assign onoff_go = (key_onoff_i && sel_r == ctop_pkg::SEL_Y) || ch1_onoff_i;

	// offset values, as fractions of full scale
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			xofs_r <= ctop_pkg::OFS_RST;
			yofs_r <= ctop_pkg::OFS_RST;
		end else if (auto_go) begin
			xofs_r <= sat16(-(($signed({{24{raw_r.x[SW-1]}}, raw_r.x}) <<< ctop_pkg::PCT_SHIFT)
				>>> sens_shift_i));
			yofs_r <= sat16(-(($signed({{24{raw_r.y[SW-1]}}, raw_r.y}) <<< ctop_pkg::PCT_SHIFT)
				>>> sens_shift_i));
		end else if (rot_done_r) begin
			xofs_r <= sat16(gx);
			yofs_r <= sat16(gy);
		end else if (knob_step_i && view_offs_r) begin
			yofs_r <= sat16(40'(yofs_r) + (knob_up_i ? 40'(ctop_pkg::KNOB_STEP)
				: -40'(ctop_pkg::KNOB_STEP)));
		end else if (reg_wr_i && reg_addr_i == ctop_pkg::REG_XOFS) begin
			xofs_r <= reg_wdata_i[15:0];
		end else if (reg_wr_i && reg_addr_i == ctop_pkg::REG_YOFS) begin
			yofs_r <= reg_wdata_i[15:0];
		end
	end

	// one enable for both offsets; values are kept while off
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ofs_en_r <= 1'b0;
		end else if (auto_go) begin
			ofs_en_r <= 1'b1;
		end else if (onoff_go) begin
			ofs_en_r <= !ofs_en_r;
		end else if (reg_wr_i && reg_addr_i == ctop_pkg::REG_CTRL) begin
			ofs_en_r <= reg_wdata_i[ctop_pkg::CTRL_EN_BIT];
		end
	end

	// display selection and reference display view
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sel_r <= ctop_pkg::SEL_Y;
			view_offs_r <= 1'b0;
		end else begin
			if (key_display_i) begin
				sel_r <= (sel_r == ctop_pkg::SEL_AUX2) ? ctop_pkg::SEL_Y
					: ctop_pkg::ctop_sel_t'(sel_r + 3'h1);
			end else if (reg_wr_i && reg_addr_i == ctop_pkg::REG_CTRL
				&& reg_wdata_i[2:0] < 3'(ctop_pkg::SEL_COUNT)) begin
				sel_r <= ctop_pkg::ctop_sel_t'(reg_wdata_i[ctop_pkg::CTRL_SEL_LSB +: 3]);
			end
			if (key_ref_view_i || (key_display_i && sel_r == ctop_pkg::SEL_Y)) begin
				view_offs_r <= 1'b0;
			end else if (key_modify_i && sel_r == ctop_pkg::SEL_Y) begin
				view_offs_r <= 1'b1;
			end
		end
	end

	// display, bar-graph and readout pacing
	generate
		for (genvar g = 0; g < 3; g++) begin : g_tick
			logic [31:0] tcnt_r;
			always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
				if (sys_rst_i) begin
					tcnt_r <= 32'h00000000;
				end else if (tcnt_r == PER[g] - 1) begin
					tcnt_r <= 32'h00000000;
				end else begin
					tcnt_r <= tcnt_r + 32'h00000001;
				end
			end
			assign tick[g] = tcnt_r == PER[g] - 1;
		end
	endgenerate

	assign noise_per = (tc_us_i <= ctop_pkg::NOISE_FAST_TC_US) ? 40'(READ_CYC)
		: ((40'(tc_us_i) * 40'(ctop_pkg::NOISE_MUL)) >> ctop_pkg::NOISE_DIV_SHIFT);
	assign noise_tick = noise_cnt_r >= noise_per - 40'h1;
	assign ndiff = CW'(ry_r) - navg_r;
	assign nabs = ndiff[CW-1] ? -ndiff : ndiff;

	// noise from the ratioed quadrature stream
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			noise_cnt_r <= 40'h0;
			navg_r <= '0;
			ndev_r <= '0;
			noise_v_r <= '0;
			noise_dbm_r <= ctop_pkg::DBM_FLOOR_CENTI;
		end else begin
			noise_cnt_r <= noise_tick ? 40'h0 : noise_cnt_r + 40'h1;
			if (done_r) begin
				navg_r <= navg_r + (ndiff >>> 4);
				ndev_r <= ndev_r + ((nabs - ndev_r) >>> 4);
			end
			if (noise_tick) begin
				noise_v_r <= ndev_r;
				noise_dbm_r <= to_dbm(ndev_r);
			end
		end
	end

	always_comb begin
		case (sel_r)
			ctop_pkg::SEL_Y: qty = 32'(ry_r);
			ctop_pkg::SEL_PHASE: qty = phase_cd_r;
			ctop_pkg::SEL_NOISE_V: qty = 32'(noise_v_r);
			ctop_pkg::SEL_NOISE_DBM: qty = noise_dbm_r;
			ctop_pkg::SEL_AUX2: qty = 32'(aux2_i);
			default: qty = 32'sh00000000;
		endcase
	end

	// paced outputs and indicators
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			disp_value_o <= 32'sh00000000;
			bar_value_o <= 32'sh00000000;
			readout_value_o <= 32'sh00000000;
			readout_stb_o <= 1'b0;
			x_out_o <= '0;
			x_out_stb_o <= 1'b0;
			y_out_o <= '0;
			y_out_stb_o <= 1'b0;
			xq_cnt_r <= 2'h0;
			overflow_o <= 1'b0;
			underflow_o <= 1'b0;
		end else begin
			if (tick[0]) begin
				disp_value_o <= qty;
			end
			if (tick[1]) begin
				bar_value_o <= qty;
			end
			readout_stb_o <= tick[2];
			if (tick[2]) begin
				readout_value_o <= qty;
			end
			y_out_stb_o <= done_r;
			x_out_stb_o <= 1'b0;
			if (done_r) begin
				y_out_o <= ry_r;
				xq_cnt_r <= xq_cnt_r + 2'h1;
				if (xq_cnt_r == 2'h3 || !(slope_i == ctop_pkg::SLOPE_18
					|| slope_i == ctop_pkg::SLOPE_24)) begin
					x_out_o <= rx_r;
					x_out_stb_o <= 1'b1;
				end
			end
			overflow_o <= ratio_on && aux_mag > 16'(ctop_pkg::AUX_OVER_MV);
			underflow_o <= ratio_on && aux_mag < 16'(ctop_pkg::AUX_UNDER_MV);
		end
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			reg_rdata_o <= 32'h00000000;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				ctop_pkg::REG_CTRL: reg_rdata_o <= {28'h0000000, ofs_en_r, sel_r};
				ctop_pkg::REG_XOFS: reg_rdata_o <= {{16{xofs_r[15]}}, xofs_r};
				ctop_pkg::REG_YOFS: reg_rdata_o <= {{16{yofs_r[15]}}, yofs_r};
				ctop_pkg::REG_STAT: reg_rdata_o <= {25'h0000000, st_r != ST_IDLE,
					underflow_o, overflow_o, ofs_en_r, sel_r};
				ctop_pkg::REG_READ: reg_rdata_o <= readout_value_o;
				default: reg_rdata_o <= 32'h00000000;
			endcase
		end else begin
			reg_rdata_o <= 32'h00000000;
		end
	end

	always_comb begin
		for (int s = 0; s < 5; s++) begin
			disp_ind_o[s] = sel_r == ctop_pkg::ctop_sel_t'(s);
		end
	end

	assign offs_ind_o = ofs_en_r && (sel_r == ctop_pkg::SEL_Y
		|| sel_r == ctop_pkg::SEL_PHASE);
	assign ratio_ind_o = {ratio_mode_i == ctop_pkg::RATIO_AUX2,
		ratio_mode_i == ctop_pkg::RATIO_AUX1};
	assign ref_show_offs_o = view_offs_r;
	assign ref_offs_pct_o = yofs_r;
endmodule // ctop_core

// ### ctop_core_assertions.sv
// assertions on the channel-two processing ports
`timescale 1ns/1ps
module ctop_core_assertions (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire ctop_pkg::ctop_ratio_t ratio_mode_i,
	input wire logic signed [15:0] aux2_i,
	input wire logic key_auto_i,
	input wire logic key_modify_i,
	input wire logic key_ref_view_i,
	input wire logic [4:0] disp_ind_o,
	input wire logic offs_ind_o,
	input wire logic [1:0] ratio_ind_o,
	input wire logic overflow_o,
	input wire logic underflow_o,
	input wire logic ref_show_offs_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);
	sequence s_mod_y; key_modify_i && disp_ind_o[0] && !key_ref_view_i; endsequence
	sequence s_auto_y; key_auto_i && disp_ind_o[0]; endsequence
	property p_sel; $onehot(disp_ind_o); endproperty
	a_sel: assert property (p_sel) else $error("selection not one-hot");
	property p_ovf; (ratio_mode_i == ctop_pkg::RATIO_AUX2 && aux2_i > 16'sh2904)[*2]
		|-> overflow_o; endproperty
	a_ovf: assert property (p_ovf) else $error("overflow missing");
	property p_unf; (ratio_mode_i == ctop_pkg::RATIO_AUX2 && aux2_i < 16'sh0032
		&& aux2_i > -16'sh0032)[*2] |-> underflow_o; endproperty
	a_unf: assert property (p_unf) else $error("underflow missing");
	property p_off; (ratio_mode_i == ctop_pkg::RATIO_OFF)[*2] |-> !overflow_o && !underflow_o;
	endproperty
	a_off: assert property (p_off) else $error("range flag with ratio off");
	property p_rind; (ratio_mode_i == ctop_pkg::RATIO_OFF)[*2] |-> ratio_ind_o == 2'h0; endproperty
	a_rind: assert property (p_rind) else $error("ratio indicator lit");
	property p_auxofs; disp_ind_o[4] |-> !offs_ind_o; endproperty
	a_auxofs: assert property (p_auxofs) else $error("offset lit on aux");
	property p_mod; s_mod_y |=> ref_show_offs_o; endproperty
	a_mod: assert property (p_mod) else $error("modify not shown");
	property p_auto; s_auto_y |-> ##[1:4] offs_ind_o; endproperty
	a_auto: assert property (p_auto) else $error("auto did not enable");
endmodule // ctop_core_assertions
bind ctop_core ctop_core_assertions i_ctop_core_assertions (.*);

// ### ctop_panel.sv
// front panel model: key code to one-cycle key pulses
`timescale 1ns/1ps
module ctop_panel (
	input wire logic core_clk_i,
	input wire logic [2:0] key_code_i,
	output logic [6:0] keys_o
);
	always_ff @(posedge core_clk_i) begin
		for (int k = 0; k < 7; k++) keys_o[k] <= (key_code_i == 3'(k + 1));
	end
endmodule // ctop_panel

// ### ctop_tb.sv
// self-checking bench for the channel-two processing block
`timescale 1ns/1ps
module testbench;
	logic core_clk_i = 0, sys_rst_i = 1, sample_valid_i = 0, reg_wr_i = 0, reg_rd_i = 0;
	logic key_display_i, key_onoff_i, key_auto_i, key_modify_i, key_ref_view_i, ch1_auto_i;
	logic ch1_onoff_i, knob_step_i = 0, knob_up_i = 0, sample_ready_o, readout_stb_o;
	logic x_out_stb_o, y_out_stb_o, offs_ind_o, overflow_o, underflow_o, ref_show_offs_o;
	logic [1:0] ratio_ind_o;
	logic [2:0] code = 3'h0;
	logic [3:0] sens_shift_i = 4'hF;
	logic [4:0] disp_ind_o;
	logic [7:0] reg_addr_i = 8'h00;
	logic [15:0] ref_phase_i = 16'h0000;
	logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, tc_us_i = 32'h3E8;
	logic signed [15:0] aux1_i = 16'sh03E8, aux2_i = 16'sh03E8, ref_offs_pct_o, x, y;
	logic signed [15:0] av [5] = '{16'sh2905, 16'sh2904, -16'sh2905, 16'sh0031, 16'sh0032};
	logic [1:0] ev [5] = '{2'h2, 2'h0, 2'h2, 2'h1, 2'h0};
	logic signed [17:0] x_out_o, y_out_o;
	logic signed [31:0] disp_value_o, bar_value_o, readout_value_o;
	ctop_pkg::ctop_ratio_t ratio_mode_i = ctop_pkg::RATIO_OFF;
	ctop_pkg::ctop_slope_t slope_i = ctop_pkg::SLOPE_6;
	ctop_pkg::ctop_xy_t sample_i = '0;
	logic [39:0] eq [$];
	int n_errors = 0, total_checks = 0, n_x = 0, k;
	ctop_core #(.DISP_CYC(40), .BAR_CYC(20), .READ_CYC(10)) i_ctop_core (.*);
	ctop_panel i_ctop_panel (.core_clk_i, .key_code_i(code), .keys_o({ch1_onoff_i, ch1_auto_i,
		key_ref_view_i, key_modify_i, key_auto_i, key_onoff_i, key_display_i}));
	initial forever #4 core_clk_i = ~core_clk_i;
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		{reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} <= {w, !w, a, d};
		@(posedge core_clk_i);
		{reg_wr_i, reg_rd_i} <= 2'h0;
		#1;
	endtask
	task automatic key(input logic [2:0] c);
		@(posedge core_clk_i);
		code <= c;
		@(posedge core_clk_i);
		code <= 3'h0;
		repeat (3) @(posedge core_clk_i);
		#1;
	endtask
	task automatic send(input logic signed [17:0] ex, input logic signed [17:0] ey);
		eq.push_back(40'({ex, ey}));
		@(posedge core_clk_i);
		{sample_i, sample_valid_i} <= {x, y, 1'b1};
		@(posedge core_clk_i);
		sample_valid_i <= 0;
		for (int i = 0; i < 80 && y_out_stb_o !== 1'b1; i++) @(posedge core_clk_i);
		repeat (2) @(posedge core_clk_i);
	endtask
	always @(posedge core_clk_i) begin
		if (y_out_stb_o === 1'b1)
			chk(40'({x_out_o, y_out_o}), eq.size() > 0 ? eq.pop_front() : 'x);
		if (x_out_stb_o === 1'b1) n_x++;
	end
	task automatic complete_run;
		if (eq.size() != 0) n_errors++;
		if (n_errors == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		#100us;
		n_errors++;
		complete_run();
	end
	initial begin
		void'($urandom(11));
		x = 16'($urandom_range(2000)) - 16'sh03E8;
		y = 16'($urandom_range(2000)) - 16'sh03E8;
		repeat (12) @(posedge core_clk_i);
		chk(40'({offs_ind_o, ratio_ind_o, disp_ind_o}), 40'h01);
		sys_rst_i <= 0;
		bus(0, ctop_pkg::REG_STAT, 32'h0);
		chk(40'({reg_rdata_o, sample_ready_o}), 40'h1);
		for (int i = 1; i <= 5; i++) begin
			key(3'h1);
			chk(40'(disp_ind_o), 40'(5'h01 << (i % 5)));
		end
		bus(1, ctop_pkg::REG_CTRL, 32'h5);
		bus(0, 8'h20, 32'h0);
		chk(40'({reg_rdata_o, disp_ind_o}), 40'h01);
		bus(1, ctop_pkg::REG_YOFS, 32'h100);
		bus(1, ctop_pkg::REG_XOFS, 32'h80);
		send(18'(x), 18'(y));
		repeat (41) @(posedge core_clk_i);
		chk(40'(disp_value_o), 40'(32'(y)));
		chk(40'(bar_value_o), 40'(32'(y)));
		chk(40'(readout_value_o), 40'(32'(y)));
		bus(1, ctop_pkg::REG_CTRL, 32'h1);
		repeat (11) @(posedge core_clk_i);
		chk(40'($unsigned(readout_value_o - int'($atan2(y, x) * 5729.578) + 50) <= 100),
			40'h1);
		bus(1, ctop_pkg::REG_CTRL, 32'h0);
		key(3'h2);
		chk(40'(offs_ind_o), 40'h1);
		send(18'(x) + 18'sh80, 18'(y) + 18'sh100);
		sens_shift_i <= 4'hE;
		send(18'(x) + 18'sh40, 18'(y) + 18'sh80);
		for (int m = 0; m < 3; m++) begin
			ratio_mode_i <= ctop_pkg::ctop_ratio_t'(m);
			send(18'(x) + 18'sh40, 18'(y) + 18'sh80);
			chk(40'(ratio_ind_o), 40'(m));
		end
		aux2_i <= -16'sh03E8;
		send(-18'(x) - 18'sh40, -18'(y) - 18'sh80);
		foreach (av[i]) begin
			aux2_i <= av[i];
			repeat (3) @(posedge core_clk_i);
			chk(40'({overflow_o, underflow_o}), 40'(ev[i]));
		end
		ratio_mode_i <= ctop_pkg::RATIO_OFF;
		key(3'h3);
		send(18'h0, 18'h0);
		key(3'h4);
		chk(40'(ref_show_offs_o), 40'h1);
		key(3'h5);
		key(3'h7);
		key(3'h6);
		send(18'h0, 18'h0);
		slope_i <= ctop_pkg::SLOPE_18;
		k = n_x;
		repeat (4) send(18'h0, 18'h0);
		chk(40'(n_x - k), 40'h1);
		ref_phase_i <= 16'h8000;
		repeat (30) @(posedge core_clk_i);
		chk(40'($unsigned(32'(ref_offs_pct_o) - 2 * y + 32) <= 64), 40'h1);
		complete_run();
	end
endmodule // testbench
